// file: sis_device.sv
// The AHB-Lite slave port was left to the implementer.
`default_nettype none
module sis_device
#(
	parameter int LOCK_CYCLES = sis_pkg::LOCK_TYPICAL_CYCLES
)
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// Control link
	sis_link_if.device LINK,
	// Strap
	input wire logic BOOT_FROM_MEMORY,
	// Core and clock controls
	output logic BOOT_BUSY,
	output logic SPI_MODE,
	output logic CORE_SOFT_RESET,
	output logic CORE_HIBERNATE,
	output logic CORE_HALTED,
	output logic CORE_CLK_FROM_PLL,
	output logic PLL_ON,
	output logic PLL_LOCKED,
	output logic [3:0] PLL_INPUT_DIV,
	output logic [15:0] PLL_MULT,
	output logic CLKOUT_ENABLE,
	output logic [15:0] POWER_FIRST,
	output logic [15:0] POWER_SECOND
);
	import sis_pkg::*;

	logic started;
	logic [6:0] boot_count;
	logic select_prev;
	logic [1:0] rises;
	logic [2:0] byte_idx;
	logic [7:0] addr_hi;
	logic [15:0] addr;
	logic [7:0] data_hi;
	logic lock_done;
	logic locking;
	logic port_open;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] rd_word;
	logic [15:0] pll_feedback_divider;
	logic [15:0] pll_input_prescaler;
	logic [15:0] core_clock_source_select;
	logic [15:0] pll_turn_on;
	logic [15:0] clock_output_control;
	logic [15:0] subsystem_power_first;
	logic [15:0] subsystem_power_second;
	logic [15:0] hibernate;
	logic [15:0] core_halt_control;
	logic [15:0] software_reset_control;

	// Wake once the master clock is valid, then catch the boot strap
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			started <= 1'b0;
			BOOT_BUSY <= 1'b0;
			boot_count <= '0;
		end
		else if (!started && LINK.mclk_valid)
		begin
			started <= 1'b1;
			BOOT_BUSY <= BOOT_FROM_MEMORY;
		end
		else if (BOOT_BUSY)
		begin
			boot_count <= boot_count + 7'h1;
			if (boot_count == 7'(BOOT_CYCLES - 1))
				BOOT_BUSY <= 1'b0;
		end
	end

	// Port mode from rises of the select pin
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			select_prev <= 1'b1;
			rises <= '0;
			SPI_MODE <= 1'b0;
		end
		else if (started && !BOOT_BUSY)
		begin
			select_prev <= LINK.port_select_address_pin;
			if (!SPI_MODE && LINK.port_select_address_pin && !select_prev)
			begin
				rises <= rises + 2'h1;
				if (rises == 2'(SPI_SELECT_RISES - 1))
					SPI_MODE <= 1'b1;
			end
		end
	end

	sis_lock_timer #(
		.CYCLES(LOCK_CYCLES)
	) u_lock (
		.clk(REF_CLK),
		.srst(SRST),
		.run(pll_turn_on[0]),
		.locked(lock_done)
	);

	always_comb
	begin
		locking = pll_turn_on[0] && !lock_done;
		port_open = started && !BOOT_BUSY && !locking;
		wr_data = {data_hi, LINK.cp_byte};
		wr_en = port_open && LINK.cp_frame && LINK.cp_valid && !LINK.cp_read
			&& byte_idx == 3'h3;
	end

	// Byte framing: address then data, most significant byte first
	always_ff @(posedge REF_CLK)
	begin
		if (SRST || !LINK.cp_frame)
			byte_idx <= '0;
		else if (LINK.cp_valid && byte_idx != 3'h4)
			byte_idx <= byte_idx + 3'h1;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			addr_hi <= '0;
			addr <= '0;
			data_hi <= '0;
		end
		else if (LINK.cp_frame && LINK.cp_valid)
		begin
			case (byte_idx)
				3'h0: addr_hi <= LINK.cp_byte;
				3'h1: addr <= {addr_hi, LINK.cp_byte};
				3'h2: data_hi <= LINK.cp_byte;
				default: ;
			endcase
		end
	end

	// Register writes and the controls they drive
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			pll_feedback_divider <= RST_PLL_FEEDBACK_DIVIDER;
			pll_input_prescaler <= RST_CLEAR;
			core_clock_source_select <= RST_CLEAR;
			pll_turn_on <= RST_CLEAR;
			clock_output_control <= RST_CLEAR;
			subsystem_power_first <= RST_CLEAR;
			subsystem_power_second <= RST_CLEAR;
			hibernate <= RST_CLEAR;
			core_halt_control <= RST_CLEAR;
			software_reset_control <= RST_SOFTWARE_RESET;
			CORE_SOFT_RESET <= 1'b0;
			CORE_HIBERNATE <= 1'b0;
			CORE_HALTED <= 1'b0;
			CORE_CLK_FROM_PLL <= 1'b0;
			PLL_ON <= 1'b0;
			PLL_INPUT_DIV <= sis_prescale_div(RST_CLEAR);
			CLKOUT_ENABLE <= 1'b0;
		end
		else if (wr_en)
		begin
			case (addr)
				REG_PLL_FEEDBACK_DIVIDER: pll_feedback_divider <= wr_data;
				REG_PLL_INPUT_PRESCALER:
				begin
					pll_input_prescaler <= wr_data;
					PLL_INPUT_DIV <= sis_prescale_div(wr_data);
				end
				REG_CORE_CLOCK_SOURCE_SELECT:
				begin
					core_clock_source_select <= wr_data;
					CORE_CLK_FROM_PLL <= wr_data[0];
				end
				REG_PLL_TURN_ON:
				begin
					pll_turn_on <= wr_data;
					PLL_ON <= wr_data[0];
				end
				REG_CLOCK_OUTPUT_CONTROL:
				begin
					clock_output_control <= wr_data;
					CLKOUT_ENABLE <= wr_data[0];
				end
				REG_SUBSYSTEM_POWER_FIRST: subsystem_power_first <= wr_data;
				REG_SUBSYSTEM_POWER_SECOND: subsystem_power_second <= wr_data;
				REG_HIBERNATE:
				begin
					hibernate <= wr_data;
					CORE_HIBERNATE <= wr_data[0];
				end
				REG_CORE_HALT_CONTROL:
				begin
					core_halt_control <= wr_data;
					CORE_HALTED <= wr_data[0];
				end
				REG_SOFTWARE_RESET_CONTROL:
				begin
					software_reset_control <= wr_data;
					CORE_SOFT_RESET <= !wr_data[0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			PLL_LOCKED <= 1'b0;
		else
			PLL_LOCKED <= lock_done;
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_word = '0;
		case ({addr_hi, LINK.cp_byte})
			REG_PLL_FEEDBACK_DIVIDER: rd_word = pll_feedback_divider;
			REG_PLL_INPUT_PRESCALER: rd_word = pll_input_prescaler;
			REG_CORE_CLOCK_SOURCE_SELECT: rd_word = core_clock_source_select;
			REG_PLL_TURN_ON: rd_word = pll_turn_on;
			REG_PLL_LOCK_STATUS: rd_word = {15'h0000, lock_done};
			REG_CLOCK_OUTPUT_CONTROL: rd_word = clock_output_control;
			REG_SUBSYSTEM_POWER_FIRST: rd_word = subsystem_power_first;
			REG_SUBSYSTEM_POWER_SECOND: rd_word = subsystem_power_second;
			REG_HIBERNATE: rd_word = hibernate;
			REG_CORE_HALT_CONTROL: rd_word = core_halt_control;
			REG_SOFTWARE_RESET_CONTROL: rd_word = software_reset_control;
			default: rd_word = '0;
		endcase
	end

	// Read answer one cycle after the second address byte
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			LINK.cp_rvalid <= 1'b0;
			LINK.cp_rdata <= '0;
		end
		else
		begin
			LINK.cp_rvalid <= started && !BOOT_BUSY && LINK.cp_frame && LINK.cp_valid
				&& LINK.cp_read && byte_idx == 3'h1;
			if (LINK.cp_frame && LINK.cp_valid && LINK.cp_read && byte_idx == 3'h1)
				LINK.cp_rdata <= rd_word;
		end
	end

	// Busy while asleep, booting or locking
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			LINK.cp_busy <= 1'b1;
		else
			LINK.cp_busy <= !started || BOOT_BUSY || locking;
	end

	assign PLL_MULT = pll_feedback_divider;
	assign POWER_FIRST = subsystem_power_first;
	assign POWER_SECOND = subsystem_power_second;
endmodule
`default_nettype wire

// file: sis_host.sv
`default_nettype none
module sis_host
#(
	parameter int LOCK_MAX = sis_pkg::LOCK_MAX_CYCLES
)
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	// Control link
	sis_link_if.host LINK,
	// Sequence status
	output logic SEQ_BUSY,
	output logic SEQ_DONE
);
	import sis_pkg::*;

	sis_host_state_e state;
	logic wr_pend;
	logic [7:0] wr_off;
	logic start_req;
	logic use_spi;
	logic [15:0] feedback;
	logic lock_timeout;
	logic [3:0] step;
	logic [2:0] tog;
	logic [1:0] nbyte;
	logic [WAIT_W-1:0] wait_count;
	logic addr_ok;

	function automatic logic [31:0] sis_step_word(input logic [3:0] s, input logic [15:0] fb);
		case (s)
			4'h0: return {REG_SOFTWARE_RESET_CONTROL, VAL_OFF};
			4'h1: return {REG_SOFTWARE_RESET_CONTROL, VAL_ON};
			4'h2: return {REG_HIBERNATE, VAL_OFF};
			4'h3: return {REG_HIBERNATE, VAL_ON};
			4'h4: return {REG_CORE_HALT_CONTROL, VAL_ON};
			4'h5: return {REG_PLL_FEEDBACK_DIVIDER, fb};
			4'h6: return {REG_PLL_INPUT_PRESCALER, PRESCALE_DIV4};
			4'h7: return {REG_CORE_CLOCK_SOURCE_SELECT, VAL_ON};
			4'h8: return {REG_CLOCK_OUTPUT_CONTROL, CLOCK_OUTPUT_ON};
			4'h9: return {REG_PLL_TURN_ON, VAL_ON};
			4'ha: return {REG_SUBSYSTEM_POWER_FIRST, POWER_FIRST_ON};
			default: return {REG_SUBSYSTEM_POWER_SECOND, POWER_SECOND_OFF};
		endcase
	endfunction

	assign addr_ok = HSEL && HTRANS[1] && HSIZE == HSIZE_WORD;

	// AHB address phase
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			wr_pend <= 1'b0;
			wr_off <= '0;
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else if (HREADY)
		begin
			wr_pend <= addr_ok && HWRITE;
			wr_off <= HADDR[7:0];
			if (addr_ok && !HWRITE)
			begin
				case (HADDR[7:0])
					HOST_CTRL: HRDATA <= {30'h00000000, use_spi, 1'b0};
					HOST_FEEDBACK: HRDATA <= {16'h0000, feedback};
					HOST_STATUS: HRDATA <= {21'h000000, state, 5'h00, lock_timeout,
						SEQ_BUSY, SEQ_DONE};
					default: HRDATA <= '0;
				endcase
			end
		end
	end

	// AHB data phase writes
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			use_spi <= 1'b0;
			feedback <= RST_PLL_FEEDBACK_DIVIDER;
			start_req <= 1'b0;
		end
		else
		begin
			if (state != SIS_IDLE)
				start_req <= 1'b0;
			if (wr_pend && wr_off == HOST_CTRL)
			begin
				use_spi <= HWDATA[CTRL_SPI];
				if (HWDATA[CTRL_START])
					start_req <= 1'b1;
			end
			if (wr_pend && wr_off == HOST_FEEDBACK)
				feedback <= HWDATA[15:0];
		end
	end

	// Start-up sequencer
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			state <= SIS_IDLE;
			step <= '0;
			tog <= '0;
			nbyte <= '0;
			wait_count <= '0;
			lock_timeout <= 1'b0;
			SEQ_BUSY <= 1'b0;
			SEQ_DONE <= 1'b0;
			LINK.mclk_valid <= 1'b0;
			LINK.port_select_address_pin <= 1'b1;
			LINK.cp_frame <= 1'b0;
			LINK.cp_valid <= 1'b0;
			LINK.cp_byte <= '0;
			LINK.cp_read <= 1'b0;
		end
		else
		begin
			LINK.mclk_valid <= 1'b1;
			LINK.cp_valid <= 1'b0;
			case (state)
				SIS_IDLE:
					if (start_req)
					begin
						SEQ_BUSY <= 1'b1;
						SEQ_DONE <= 1'b0;
						lock_timeout <= 1'b0;
						step <= '0;
						state <= SIS_BOOT;
					end
				SIS_BOOT:
					if (LINK.mclk_valid && !LINK.cp_busy)
					begin
						tog <= '0;
						nbyte <= '0;
						wait_count <= '0;
						if (use_spi)
						begin
							LINK.port_select_address_pin <= 1'b0;
							state <= SIS_TOGGLE;
						end
						else
							state <= SIS_SEND;
					end
				SIS_TOGGLE:
					if (wait_count == WAIT_W'(TOGGLE_CYCLES - 1))
					begin
						wait_count <= '0;
						if (tog == 3'(TOGGLE_PHASES - 1))
							state <= SIS_SEND;
						else
						begin
							tog <= tog + 3'h1;
							LINK.port_select_address_pin <= !LINK.port_select_address_pin;
						end
					end
					else
						wait_count <= wait_count + 1'b1;
				SIS_SEND:
				begin
					LINK.cp_frame <= 1'b1;
					LINK.cp_valid <= 1'b1;
					LINK.cp_read <= 1'b0;
					LINK.cp_byte <= sis_word_byte(sis_step_word(step, feedback), nbyte);
					nbyte <= nbyte + 2'h1;
					if (nbyte == 2'h3)
					begin
						state <= SIS_WAIT;
						if (step == STEP_SOFT_EXIT)
							wait_count <= WAIT_W'(SOFT_RESET_WAIT_CYCLES);
						else if (step == STEP_HIB_ON)
							wait_count <= WAIT_W'(SAMPLE_WAIT_CYCLES);
						else
							wait_count <= '0;
					end
				end
				SIS_WAIT:
				begin
					LINK.cp_frame <= 1'b0;
					if (wait_count != '0)
						wait_count <= wait_count - 1'b1;
					else if (step == STEP_PLL_ON)
						state <= SIS_POLL;
					else if (step == STEP_LAST)
					begin
						SEQ_BUSY <= 1'b0;
						SEQ_DONE <= 1'b1;
						state <= SIS_IDLE;
					end
					else
					begin
						step <= step + 4'h1;
						state <= SIS_SEND;
					end
				end
				SIS_POLL:
				begin
					LINK.cp_frame <= 1'b1;
					LINK.cp_valid <= 1'b1;
					LINK.cp_read <= 1'b1;
					LINK.cp_byte <= sis_word_byte({REG_PLL_LOCK_STATUS, VAL_OFF}, nbyte);
					nbyte <= nbyte + 2'h1;
					wait_count <= wait_count + 1'b1;
					if (nbyte == 2'h1)
						state <= SIS_RESP;
				end
				SIS_RESP:
				begin
					LINK.cp_frame <= 1'b0;
					LINK.cp_read <= 1'b0;
					nbyte <= '0;
					wait_count <= wait_count + 1'b1;
					if (wait_count >= WAIT_W'(LOCK_MAX - 1))
					begin
						lock_timeout <= 1'b1;
						step <= step + 4'h1;
						state <= SIS_SEND;
					end
					else if (LINK.cp_rvalid)
					begin
						if (LINK.cp_rdata[0])
						begin
							step <= step + 4'h1;
							state <= SIS_SEND;
						end
						else
							state <= SIS_POLL;
					end
				end
				default: state <= SIS_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: sis_link_if.sv
`default_nettype none
interface sis_link_if;
	logic mclk_valid;
	logic port_select_address_pin;
	logic cp_frame;
	logic cp_valid;
	logic [7:0] cp_byte;
	logic cp_read;
	logic cp_busy;
	logic cp_rvalid;
	logic [15:0] cp_rdata;

	modport device (
		input mclk_valid, port_select_address_pin, cp_frame, cp_valid, cp_byte, cp_read,
		output cp_busy, cp_rvalid, cp_rdata
	);
	modport host (
		output mclk_valid, port_select_address_pin, cp_frame, cp_valid, cp_byte, cp_read,
		input cp_busy, cp_rvalid, cp_rdata
	);
endinterface
`default_nettype wire

// file: sis_link_monitor.sv
`default_nettype none
module sis_link_monitor
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// Link signals
	input wire logic mclk_valid,
	input wire logic port_select_address_pin,
	input wire logic cp_frame,
	input wire logic cp_valid,
	input wire logic [7:0] cp_byte,
	input wire logic cp_read,
	input wire logic cp_busy,
	input wire logic cp_rvalid,
	input wire logic [15:0] cp_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] byte_cnt;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	// Bytes seen in the open frame
	always_ff @(posedge REF_CLK)
	begin
		if (SRST || !cp_frame)
			byte_cnt <= 3'h0;
		else if (cp_valid && byte_cnt != 3'h7)
			byte_cnt <= byte_cnt + 3'h1;
	end
	property p_busy_mclk;
		!cp_busy |-> mclk_valid;
	endproperty
	a_busy_mclk: assert property (p_busy_mclk)
		else $error("device ready without master clock");
	property p_toggle;
		$fell(port_select_address_pin) |-> !cp_busy && !cp_frame ##1 port_select_address_pin;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("select pin toggle out of place");
	property p_write_ready;
		cp_frame && cp_valid && !cp_read |-> !cp_busy;
	endproperty
	a_write_ready: assert property (p_write_ready)
		else $error("write byte sent while device busy");
	property p_valid_in_frame;
		cp_valid |-> cp_frame;
	endproperty
	a_valid_in_frame: assert property (p_valid_in_frame)
		else $error("byte outside frame");
	property p_msb_first;
		cp_valid && byte_cnt == 3'h0 |-> cp_byte[7:4] == 4'hf;
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first byte not address high");
	property p_frame_len;
		$fell(cp_frame) |-> byte_cnt == ($past(cp_read) ? 3'h2 : 3'h4);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("wrong byte count in frame");
	property p_read_answer;
		cp_frame && cp_read && cp_valid && byte_cnt == 3'h1 |=> cp_rvalid ##1 !cp_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer missing or too long");
	property p_rvalid_cause;
		cp_rvalid |-> $past(cp_read) && $past(cp_valid);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("read answer without request");
	c_read: cover property ($rose(cp_rvalid));
	c_toggle: cover property ($fell(port_select_address_pin));
	c_ready: cover property ($fell(cp_busy));
endmodule
`default_nettype wire

// file: sis_lock_timer.sv
`default_nettype none
module sis_lock_timer
#(
	parameter int CYCLES = sis_pkg::LOCK_TYPICAL_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic run,
	output logic locked
);
	import sis_pkg::*;

	logic [31:0] count;

	// Counts reference cycles while the PLL runs, holding once locked
	always_ff @(posedge clk)
	begin
		if (srst || !run)
			count <= '0;
		else if (!locked)
			count <= count + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (srst || !run)
			locked <= 1'b0;
		else if (count == 32'(CYCLES - 1))
			locked <= 1'b1;
	end
endmodule
`default_nettype wire

// file: sis_pkg.sv
`default_nettype none
package sis_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int MCLK_PERIOD_NS = 40;
	localparam int TOGGLE_CYCLES = (MCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SOFT_RESET_WAIT_NS = 650;
	localparam int SOFT_RESET_WAIT_CYCLES =
		(SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_RATE_HZ = 48000;
	localparam int SAMPLE_WAIT_CYCLES =
		(1000000000 + SAMPLE_RATE_HZ * CLK_PERIOD_NS - 1) / (SAMPLE_RATE_HZ * CLK_PERIOD_NS);
	localparam int LOCK_MAX_NS = 10666000;
	localparam int LOCK_MAX_CYCLES = LOCK_MAX_NS / CLK_PERIOD_NS;
	localparam int LOCK_TYPICAL_NS = 3500000;
	localparam int LOCK_TYPICAL_CYCLES = LOCK_TYPICAL_NS / CLK_PERIOD_NS;
	localparam int BOOT_CYCLES = 64;
	localparam int SPI_SELECT_RISES = 3;
	localparam int TOGGLE_PHASES = 2 * SPI_SELECT_RISES;
	localparam int WAIT_W = 19;
	// Device register offsets
	localparam logic [15:0] REG_PLL_FEEDBACK_DIVIDER = 16'hf000;
	localparam logic [15:0] REG_PLL_INPUT_PRESCALER = 16'hf001;
	localparam logic [15:0] REG_CORE_CLOCK_SOURCE_SELECT = 16'hf002;
	localparam logic [15:0] REG_PLL_TURN_ON = 16'hf003;
	localparam logic [15:0] REG_PLL_LOCK_STATUS = 16'hf004;
	localparam logic [15:0] REG_CLOCK_OUTPUT_CONTROL = 16'hf005;
	localparam logic [15:0] REG_SUBSYSTEM_POWER_FIRST = 16'hf050;
	localparam logic [15:0] REG_SUBSYSTEM_POWER_SECOND = 16'hf051;
	localparam logic [15:0] REG_HIBERNATE = 16'hf400;
	localparam logic [15:0] REG_CORE_HALT_CONTROL = 16'hf403;
	localparam logic [15:0] REG_SOFTWARE_RESET_CONTROL = 16'hf890;
	// Reset values
	localparam logic [15:0] RST_PLL_FEEDBACK_DIVIDER = 16'h0060;
	localparam logic [15:0] RST_SOFTWARE_RESET = 16'h0001;
	localparam logic [15:0] RST_CLEAR = 16'h0000;
	// Sequence data
	localparam logic [15:0] VAL_OFF = 16'h0000;
	localparam logic [15:0] VAL_ON = 16'h0001;
	localparam logic [15:0] PRESCALE_DIV4 = 16'h0002;
	localparam logic [15:0] CLOCK_OUTPUT_ON = 16'h0005;
	localparam logic [15:0] POWER_FIRST_ON = 16'h4fff;
	localparam logic [15:0] POWER_SECOND_OFF = 16'h0000;
	// Sequence steps
	localparam logic [3:0] STEP_SOFT_EXIT = 4'h1;
	localparam logic [3:0] STEP_HIB_ON = 4'h3;
	localparam logic [3:0] STEP_PLL_ON = 4'h9;
	localparam logic [3:0] STEP_LAST = 4'hb;
	// Host register map
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_FEEDBACK = 8'h04;
	localparam logic [7:0] HOST_STATUS = 8'h08;
	localparam int CTRL_START = 0;
	localparam int CTRL_SPI = 1;
	localparam int STATUS_DONE = 0;
	localparam int STATUS_BUSY = 1;
	localparam int STATUS_TIMEOUT = 2;
	localparam int STATUS_STATE = 8;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		SIS_IDLE = 3'h0,
		SIS_BOOT = 3'h1,
		SIS_TOGGLE = 3'h3,
		SIS_SEND = 3'h2,
		SIS_WAIT = 3'h6,
		SIS_POLL = 3'h7,
		SIS_RESP = 3'h5
	} sis_host_state_e;

	// Byte i of a word, most significant first
	function automatic logic [7:0] sis_word_byte(input logic [31:0] w, input logic [1:0] i);
		case (i)
			2'h0: return w[31:24];
			2'h1: return w[23:16];
			2'h2: return w[15:8];
			default: return w[7:0];
		endcase
	endfunction

	function automatic logic [3:0] sis_prescale_div(input logic [15:0] v);
		return 4'h1 << v[1:0];
	endfunction
endpackage
`default_nettype wire

// file: test_startup_init_sequence.sv
`default_nettype none
module test_startup_init_sequence;
	timeunit 1ns;
	timeprecision 1ns;
	import sis_pkg::*;
	localparam int LOCK_CYC = 50;
	logic REF_CLK = 1'b0;
	logic SRST = 1'b1;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h0;
	logic [31:0] HWDATA = 32'h0;
	logic BOOT_FROM_MEMORY = 1'b1;
	logic HREADYOUT, HRESP, SEQ_BUSY, SEQ_DONE, BOOT_BUSY, SPI_MODE, CORE_SOFT_RESET;
	logic CORE_HIBERNATE, CORE_HALTED, CORE_CLK_FROM_PLL, PLL_ON, PLL_LOCKED, CLKOUT_ENABLE;
	logic [31:0] HRDATA;
	logic [3:0] PLL_INPUT_DIV;
	logic [15:0] PLL_MULT, POWER_FIRST, POWER_SECOND;
	int fail_count = 0;
	int cmp_count = 0;
	int rises, hib_wait, lock_wait;
	logic prev_pin, prev_rst, saw_sr, saw_boot, halt_seen, pwr_seen;
	sis_link_if link ();
	sis_host #(.LOCK_MAX(2000)) i_sis_host (.REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
		.LINK(link.host), .SEQ_BUSY(SEQ_BUSY), .SEQ_DONE(SEQ_DONE));
	sis_device #(.LOCK_CYCLES(LOCK_CYC)) i_sis_device (.REF_CLK(REF_CLK), .SRST(SRST),
		.LINK(link.device), .BOOT_FROM_MEMORY(BOOT_FROM_MEMORY), .BOOT_BUSY(BOOT_BUSY),
		.SPI_MODE(SPI_MODE), .CORE_SOFT_RESET(CORE_SOFT_RESET), .CORE_HIBERNATE(CORE_HIBERNATE),
		.CORE_HALTED(CORE_HALTED), .CORE_CLK_FROM_PLL(CORE_CLK_FROM_PLL), .PLL_ON(PLL_ON),
		.PLL_LOCKED(PLL_LOCKED), .PLL_INPUT_DIV(PLL_INPUT_DIV), .PLL_MULT(PLL_MULT),
		.CLKOUT_ENABLE(CLKOUT_ENABLE), .POWER_FIRST(POWER_FIRST), .POWER_SECOND(POWER_SECOND));
	sis_link_monitor i_sis_link_monitor (.REF_CLK(REF_CLK), .SRST(SRST),
		.mclk_valid(link.mclk_valid), .port_select_address_pin(link.port_select_address_pin),
		.cp_frame(link.cp_frame), .cp_valid(link.cp_valid), .cp_byte(link.cp_byte),
		.cp_read(link.cp_read), .cp_busy(link.cp_busy), .cp_rvalid(link.cp_rvalid),
		.cp_rdata(link.cp_rdata));
	initial
	begin
		forever #20 REF_CLK = ~REF_CLK;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		HSEL <= 1'b1;
		HADDR <= {24'h0, a};
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HSIZE <= HSIZE_WORD;
		@(posedge REF_CLK);
		while (HREADYOUT !== 1'b1)
			@(posedge REF_CLK);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		@(posedge REF_CLK);
		while (HREADYOUT !== 1'b1)
			@(posedge REF_CLK);
		rd = HRDATA;
	endtask
	// Tracks pin rises and the timing of core and clock events
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			rises = 0;
			prev_pin = 1'b1;
			{saw_sr, saw_boot, halt_seen, pwr_seen} = 4'h0;
			hib_wait = 0;
			lock_wait = 0;
		end
		else
		begin
			if (!prev_rst)
				check(32'(SPI_MODE), 32'(rises >= SPI_SELECT_RISES));
			if (link.port_select_address_pin === 1'b1 && prev_pin === 1'b0)
				rises++;
			prev_pin = link.port_select_address_pin;
			saw_sr |= (CORE_SOFT_RESET === 1'b1);
			saw_boot |= (BOOT_BUSY === 1'b1);
			if (CORE_HIBERNATE === 1'b1 && CORE_HALTED !== 1'b1)
				hib_wait++;
			if (PLL_ON === 1'b1 && PLL_LOCKED !== 1'b1)
				lock_wait++;
			if (CORE_HALTED === 1'b1 && !halt_seen)
				check(32'(hib_wait >= SAMPLE_WAIT_CYCLES), 32'h1);
			halt_seen |= (CORE_HALTED === 1'b1);
			if (POWER_FIRST === POWER_FIRST_ON && !pwr_seen)
				check(32'(PLL_LOCKED === 1'b1 && lock_wait >= LOCK_CYC), 32'h1);
			pwr_seen |= (POWER_FIRST === POWER_FIRST_ON);
		end
		prev_rst = SRST;
	end
	task automatic run_seq(input logic boot, input logic spi, input logic [15:0] fb);
		logic [31:0] v;
		int n;
		BOOT_FROM_MEMORY <= boot;
		SRST <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		SRST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		check({PLL_MULT, 12'h0, PLL_INPUT_DIV}, {RST_PLL_FEEDBACK_DIVIDER, 16'h1});
		ahb(1'b0, HOST_FEEDBACK, 32'h0, v);
		check(v, 32'h60);
		check(32'({HREADYOUT, HRESP}), 32'h2);
		ahb(1'b0, 8'h0c, 32'h0, v);
		check(v, 32'h0);
		ahb(1'b1, HOST_FEEDBACK, {16'h0, fb}, v);
		ahb(1'b1, HOST_CTRL, {30'h0, spi, 1'b1}, v);
		repeat (2) @(posedge REF_CLK);
		ahb(1'b0, HOST_STATUS, 32'h0, v);
		check({30'h0, v[STATUS_BUSY:STATUS_DONE]}, 32'h2);
		n = 0;
		while (v[STATUS_DONE] !== 1'b1 && n < 5000)
		begin
			ahb(1'b0, HOST_STATUS, 32'h0, v);
			n++;
		end
		check(32'(v[2:0]), 32'h1);
		check(32'({saw_boot, saw_sr, BOOT_BUSY, SPI_MODE, CORE_SOFT_RESET}),
			32'({boot, 2'h2, spi, 1'b0}));
		check(32'({CORE_HIBERNATE, CORE_HALTED, CORE_CLK_FROM_PLL, CLKOUT_ENABLE}), 32'hf);
		check(32'({PLL_ON, PLL_LOCKED, PLL_INPUT_DIV}), 32'({2'h3, 4'h4}));
		check({PLL_MULT, POWER_FIRST}, {fb, POWER_FIRST_ON});
		check({POWER_SECOND, 14'h0, SEQ_BUSY, SEQ_DONE}, {POWER_SECOND_OFF, 16'h1});
		$display("Test done: boot %0d spi %0d", boot, spi);
	endtask
	task automatic close_out;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#(40 * 30000);
		fail_count++;
		close_out();
	end
	initial
	begin
		run_seq(1'b1, 1'b1, 16'h0050);
		run_seq(1'b0, 1'b0, 16'h0060);
		close_out();
	end
endmodule
`default_nettype wire
